/* File: rtl/secar_defines.vh */
`ifndef SECAR_DEFINES_VH
`define SECAR_DEFINES_VH
// ----------------------------------------
// widths
// ----------------------------------------
`define SECAR_DW        68
`define SECAR_ZERO      68'h0
// ----------------------------------------
// register map (word addresses)
// ----------------------------------------
`define SECAR_OFF_CMP   6'h00
`define SECAR_OFF_MASK  6'h20
`define SECAR_OFF_HIX   6'h30
`define SECAR_OFF_CTRL  6'h38
`define SECAR_OFF_DEVICE_INFORMATION  6'h39
`define SECAR_OFF_RBUR  6'h3A
`define SECAR_OFF_WBUR  6'h3B
`define SECAR_OFF_NFREE 6'h3C
`define SECAR_CTRL_RST  68'h4
`define SECAR_CTL_SRST  0
`define SECAR_CTL_DEVE  1
`define SECAR_CTL_LAST  7
// arbitrary value, names no part
`define SECAR_DEVICE_INFORMATION_CODE 16'h0A5C
// ----------------------------------------
// command bus
// ----------------------------------------
`define SECAR_CMD_OP    1:0
`define SECAR_CMD_MSEL  4:2
`define SECAR_CMD_CPR   8:5
`define SECAR_CMD_HIX   4:2
`define SECAR_OP_RD     2'h0
`define SECAR_OP_WR     2'h1
`define SECAR_OP_SRCH   2'h2
// ----------------------------------------
// address word on dq
// ----------------------------------------
`define SECAR_DQ_RADR   5:0
`define SECAR_DQ_AADR   14:0
`define SECAR_DQ_ARR    19
`define SECAR_DQ_IND    20
`define SECAR_DQ_HIX    23:21
`define SECAR_DQ_ID     28:24
`define SECAR_ID_BCAST  5'h1F
// ----------------------------------------
// index register fields, entry sizes
// ----------------------------------------
`define SECAR_HIX_IDX   14:0
`define SECAR_HIX_VLD   31
`define SECAR_ES_136    2'h2
`define SECAR_ES_272    2'h3
`define SECAR_LSB1_CLR  15'h7FFE
`define SECAR_LSB2_CLR  15'h7FFC
// ----------------------------------------
// sequencer states
// ----------------------------------------
`define SECAR_ST_IDLE   2'h0
`define SECAR_ST_WDATA  2'h1
`define SECAR_ST_SRCHB  2'h2
`define SECAR_ST_RES    2'h3
`endif

/* File: rtl/secar_clk_phase.v */
`timescale 1ns/100ps
`default_nettype none
module secar_clk_phase (
   input  wire clk_sys,
   input  wire reset_n,
   input  wire clock_phase_n,
   output reg  clk_en_ff
);
   reg [2:0] ph_sync_ff;
   wire      ph_moving;

   // pin toggles each cycle: a live phase shows as stages two and three differing
   assign ph_moving = (ph_sync_ff[1] != ph_sync_ff[2]);

   // ----------------------------------------
   // phase filter, one internal cycle per low phase
   // ----------------------------------------
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ph_sync_ff <= 3'h7;
         clk_en_ff  <= 1'b0;
      end else begin
         ph_sync_ff <= {ph_sync_ff[1:0], clock_phase_n};
         // a stuck phase pin stops the internal cycle
         clk_en_ff  <= ph_moving & ~ph_sync_ff[1];
      end
   end
endmodule // secar_clk_phase
`default_nettype wire

/* File: rtl/secar_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "secar_defines.vh"
module secar_top (
   input  wire        clk_sys,
   input  wire        reset_n,
   input  wire        clock_phase_n,
   input  wire [4:0]  dev_id,
   input  wire        cmd_valid,
   input  wire [8:0]  cmd,
   input  wire [67:0] dq_in,
   output reg  [67:0] dq_out_ff,
   output reg         dq_oe_n_ff,
   output reg         ack_ff,
   input  wire [6:0]  local_hit_in,
   input  wire [2:0]  block_hit_in,
   input  wire [6:0]  full_chain_in,
   output reg  [1:0]  local_hit_out_ff,
   output reg  [2:0]  block_hit_out_ff,
   output reg  [1:0]  full_chain_out_ff,
   output reg         full_flag_ff,
   output reg         search_hit_flag_ff,
   output reg         search_hit_valid_ff,
   output reg  [67:0] key_ff,
   output reg  [67:0] key_care_ff,
   output reg         key_strobe_ff,
   output reg         key_second_ff,
   input  wire        core_hit,
   input  wire [14:0] core_hit_index,
   input  wire [1:0]  core_entry_size,
   input  wire        core_all_full,
   input  wire [14:0] core_next_free,
   output reg         arr_req_ff,
   output reg         arr_we_ff,
   output reg  [14:0] arr_addr_ff,
   output reg  [67:0] arr_wdata_ff,
   output reg  [67:0] arr_wmask_ff,
   input  wire        arr_rvalid,
   input  wire [67:0] arr_rdata
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   reg [67:0] cmp_mem_ff  [0:31];
   reg [67:0] mask_mem_ff [0:15];
   reg [14:0] hix_idx_ff  [0:7];
   reg [7:0]  hix_vld_ff;
   reg [67:0] ctrl_ff;
   reg [67:0] rbur_ff;
   reg [67:0] wbur_ff;
   reg [1:0]  state_ff;
   reg [67:0] wadr_ff;
   reg [2:0]  msk_sel_ff;
   reg [3:0]  cpr_sel_ff;
   reg [2:0]  hix_sel_ff;
   reg [7:0]  nxt_hix_vld;
   wire       clk_en;
   wire       deve;
   wire       last_dev;
   wire       upstream_hit;
   wire       glob_win;
   wire [1:0] op;

   assign deve         = ctrl_ff[`SECAR_CTL_DEVE];
   assign last_dev     = ctrl_ff[`SECAR_CTL_LAST];
   assign upstream_hit = (|local_hit_in) | (|block_hit_in);
   assign glob_win     = core_hit & ~upstream_hit;
   assign op           = cmd[`SECAR_CMD_OP];

   secar_clk_phase u_clk_phase (
      .clk_sys       (clk_sys),
      .reset_n       (reset_n),
      .clock_phase_n (clock_phase_n),
      .clk_en_ff     (clk_en)
   );

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function own_sel;
      input [67:0] w;
      input        rd;
      begin
         if (w[`SECAR_DQ_ID] == `SECAR_ID_BCAST) begin
            own_sel = rd ? last_dev : 1'b1;
         end else begin
            own_sel = (w[`SECAR_DQ_ID] == dev_id);
         end
      end
   endfunction

   function [14:0] trim_idx;
      input [14:0] idx;
      input [1:0]  es;
      begin
         case (es)
            `SECAR_ES_136: trim_idx = idx & `SECAR_LSB1_CLR;
            `SECAR_ES_272: trim_idx = idx & `SECAR_LSB2_CLR;
            default:       trim_idx = idx;
         endcase
      end
   endfunction

   function [67:0] reg_rd;
      input [5:0] a;
      begin
         reg_rd = `SECAR_ZERO;
         if (a < `SECAR_OFF_MASK) begin
            reg_rd = cmp_mem_ff[a[4:0]];
         end else if (a < `SECAR_OFF_HIX) begin
            reg_rd = mask_mem_ff[a[3:0]];
         end else if (a < `SECAR_OFF_CTRL) begin
            reg_rd[`SECAR_HIX_IDX] = hix_idx_ff[a[2:0]];
            reg_rd[`SECAR_HIX_VLD] = hix_vld_ff[a[2:0]];
         end else begin
            case (a)
               `SECAR_OFF_CTRL:  reg_rd = ctrl_ff;
               `SECAR_OFF_DEVICE_INFORMATION:  reg_rd = {47'h0, `SECAR_DEVICE_INFORMATION_CODE, dev_id};
               `SECAR_OFF_RBUR:  reg_rd = rbur_ff;
               `SECAR_OFF_WBUR:  reg_rd = wbur_ff;
               `SECAR_OFF_NFREE: reg_rd = {53'h0, core_next_free};
               default:          reg_rd = `SECAR_ZERO;
            endcase
         end
      end
   endfunction

   // ----------------------------------------
   // sequencer and host bus
   // ----------------------------------------
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_ff      <= `SECAR_ST_IDLE;
         wadr_ff       <= `SECAR_ZERO;
         msk_sel_ff    <= 3'h0;
         cpr_sel_ff    <= 4'h0;
         hix_sel_ff    <= 3'h0;
         ctrl_ff       <= `SECAR_CTRL_RST;
         rbur_ff       <= `SECAR_ZERO;
         wbur_ff       <= `SECAR_ZERO;
         dq_out_ff     <= `SECAR_ZERO;
         dq_oe_n_ff    <= 1'b1;
         ack_ff        <= 1'b0;
         arr_req_ff    <= 1'b0;
         arr_we_ff     <= 1'b0;
         arr_addr_ff   <= 15'h0;
         arr_wdata_ff  <= `SECAR_ZERO;
         arr_wmask_ff  <= `SECAR_ZERO;
         key_ff        <= `SECAR_ZERO;
         key_care_ff   <= `SECAR_ZERO;
         key_strobe_ff <= 1'b0;
         key_second_ff <= 1'b0;
      end else begin
         arr_req_ff    <= 1'b0;
         key_strobe_ff <= 1'b0;
         if (arr_rvalid) begin
            dq_out_ff  <= arr_rdata;
            dq_oe_n_ff <= 1'b0;
            ack_ff     <= 1'b1;
         end else if (clk_en) begin
            dq_oe_n_ff <= 1'b1;
            ack_ff     <= 1'b0;
         end
         if (clk_en) begin
            case (state_ff)
               `SECAR_ST_IDLE: begin
                  if (cmd_valid && op == `SECAR_OP_RD) begin
                     if (!dq_in[`SECAR_DQ_ARR]) begin
                        if (own_sel(dq_in, 1'b1) && deve) begin
                           dq_out_ff  <= reg_rd(dq_in[`SECAR_DQ_RADR]);
                           dq_oe_n_ff <= 1'b0;
                           ack_ff     <= 1'b1;
                        end
                     end else if (dq_in[`SECAR_DQ_IND]) begin
                        if (hix_vld_ff[dq_in[`SECAR_DQ_HIX]]) begin
                           arr_req_ff  <= 1'b1;
                           arr_we_ff   <= 1'b0;
                           arr_addr_ff <= hix_idx_ff[dq_in[`SECAR_DQ_HIX]];
                        end
                     end else if (own_sel(dq_in, 1'b1)) begin
                        arr_req_ff  <= 1'b1;
                        arr_we_ff   <= 1'b0;
                        arr_addr_ff <= dq_in[`SECAR_DQ_AADR];
                     end
                  end else if (cmd_valid && op == `SECAR_OP_WR) begin
                     wadr_ff    <= dq_in;
                     msk_sel_ff <= cmd[`SECAR_CMD_MSEL];
                     state_ff   <= `SECAR_ST_WDATA;
                  end else if (cmd_valid && op == `SECAR_OP_SRCH) begin
                     msk_sel_ff    <= cmd[`SECAR_CMD_MSEL];
                     cpr_sel_ff    <= cmd[`SECAR_CMD_CPR];
                     key_ff        <= dq_in;
                     key_care_ff   <= mask_mem_ff[{cmd[`SECAR_CMD_MSEL], 1'b0}];
                     key_strobe_ff <= 1'b1;
                     key_second_ff <= 1'b0;
                     state_ff      <= `SECAR_ST_SRCHB;
                  end
               end
               `SECAR_ST_WDATA: begin
                  state_ff <= `SECAR_ST_IDLE;
                  if (!wadr_ff[`SECAR_DQ_ARR]) begin
                     if (own_sel(wadr_ff, 1'b0)) begin
                        case (wadr_ff[`SECAR_DQ_RADR])
                           `SECAR_OFF_CTRL: begin
                              ctrl_ff <= dq_in;
                              ctrl_ff[`SECAR_CTL_SRST] <= 1'b0;
                           end
                           `SECAR_OFF_RBUR: rbur_ff <= dq_in;
                           `SECAR_OFF_WBUR: wbur_ff <= dq_in;
                           default: ;
                        endcase
                     end
                  end else if (wadr_ff[`SECAR_DQ_IND]) begin
                     if (hix_vld_ff[wadr_ff[`SECAR_DQ_HIX]]) begin
                        arr_req_ff   <= 1'b1;
                        arr_we_ff    <= 1'b1;
                        arr_addr_ff  <= hix_idx_ff[wadr_ff[`SECAR_DQ_HIX]];
                        arr_wdata_ff <= dq_in;
                        arr_wmask_ff <= mask_mem_ff[{msk_sel_ff, 1'b0}];
                     end
                  end else if (own_sel(wadr_ff, 1'b0)) begin
                     arr_req_ff   <= 1'b1;
                     arr_we_ff    <= 1'b1;
                     arr_addr_ff  <= wadr_ff[`SECAR_DQ_AADR];
                     arr_wdata_ff <= dq_in;
                     arr_wmask_ff <= mask_mem_ff[{msk_sel_ff, 1'b0}];
                  end
               end
               `SECAR_ST_SRCHB: begin
                  hix_sel_ff    <= cmd[`SECAR_CMD_HIX];
                  key_ff        <= dq_in;
                  key_care_ff   <= mask_mem_ff[{msk_sel_ff, 1'b1}];
                  key_strobe_ff <= 1'b1;
                  key_second_ff <= 1'b1;
                  state_ff      <= `SECAR_ST_RES;
               end
               `SECAR_ST_RES: begin
                  state_ff <= `SECAR_ST_IDLE;
               end
               default: state_ff <= `SECAR_ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // register arrays, no reset value
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (clk_en && state_ff == `SECAR_ST_IDLE && cmd_valid && op == `SECAR_OP_SRCH) begin
         cmp_mem_ff[{cmd[`SECAR_CMD_CPR], 1'b0}] <= dq_in;
      end
      if (clk_en && state_ff == `SECAR_ST_SRCHB) begin
         cmp_mem_ff[{cpr_sel_ff, 1'b1}] <= dq_in;
      end
      if (clk_en && state_ff == `SECAR_ST_WDATA && !wadr_ff[`SECAR_DQ_ARR] &&
          own_sel(wadr_ff, 1'b0) && wadr_ff[`SECAR_DQ_RADR] >= `SECAR_OFF_MASK &&
          wadr_ff[`SECAR_DQ_RADR] < `SECAR_OFF_HIX) begin
         mask_mem_ff[wadr_ff[3:0]] <= dq_in;
      end
      if (clk_en && state_ff == `SECAR_ST_RES && core_hit) begin
         hix_idx_ff[hix_sel_ff] <= trim_idx(core_hit_index, core_entry_size);
      end
   end

   // ----------------------------------------
   // index valid bits
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_vld
         always @* begin
            nxt_hix_vld[gi] = hix_vld_ff[gi];
            if (clk_en && state_ff == `SECAR_ST_RES && glob_win && hix_sel_ff == gi) begin
               nxt_hix_vld[gi] = 1'b1;
            end
         end
         always @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               hix_vld_ff[gi] <= 1'b0;
            end else begin
               hix_vld_ff[gi] <= nxt_hix_vld[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // cascade outputs
   // ----------------------------------------
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         local_hit_out_ff    <= 2'h0;
         block_hit_out_ff    <= 3'h0;
         full_chain_out_ff   <= 2'h0;
         full_flag_ff        <= 1'b0;
         search_hit_flag_ff  <= 1'b0;
         search_hit_valid_ff <= 1'b0;
      end else begin
         full_chain_out_ff <= {2{core_all_full}};
         full_flag_ff      <= core_all_full & (&full_chain_in);
         if (clk_en) begin
            local_hit_out_ff    <= 2'h0;
            block_hit_out_ff    <= 3'h0;
            search_hit_flag_ff  <= 1'b0;
            search_hit_valid_ff <= 1'b0;
            if (state_ff == `SECAR_ST_RES && deve) begin
               local_hit_out_ff <= {2{core_hit}};
               if (last_dev) begin
                  block_hit_out_ff <= {3{core_hit | (|local_hit_in)}};
               end
               if (glob_win) begin
                  search_hit_flag_ff  <= 1'b1;
                  search_hit_valid_ff <= 1'b1;
               end else if (last_dev && !core_hit && !upstream_hit) begin
                  search_hit_valid_ff <= 1'b1;
               end
            end
         end
      end
   end
endmodule // secar_top
`default_nettype wire

/* File: bench/secar_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// cascade and bus checks
// ----------------------------------------
module secar_chk (
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        core_all_full,
   input wire logic [6:0]  full_chain_in,
   input wire logic [1:0]  local_hit_out_ff,
   input wire logic [2:0]  block_hit_out_ff,
   input wire logic [1:0]  full_chain_out_ff,
   input wire logic        full_flag_ff,
   input wire logic        ack_ff,
   input wire logic        dq_oe_n_ff,
   input wire logic        key_strobe_ff,
   input wire logic        key_second_ff,
   input wire logic        search_hit_flag_ff,
   input wire logic        search_hit_valid_ff,
   input wire logic        arr_req_ff
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   chk_local_hit_same: assert property (local_hit_out_ff[1] == local_hit_out_ff[0])
      else $error("local hit out bits differ");
   chk_block_hit_bits: assert property (block_hit_out_ff == 3'h0 || block_hit_out_ff == 3'h7)
      else $error("block hit out bits differ");
   chk_full_out_follows: assert property ($past(reset_n) |-> full_chain_out_ff == {2{$past(core_all_full)}})
      else $error("full chain out does not follow core");
   chk_full_flag_and: assert property ($past(reset_n) |->
      full_flag_ff == ($past(core_all_full) && (&$past(full_chain_in))))
      else $error("table full flag wrong");
   chk_ack_drives_bus: assert property (dq_oe_n_ff == !ack_ff)
      else $error("bus enable not tied to ack");
   chk_ack_length: assert property ($rose(ack_ff) |-> ##[1:2] !ack_ff)
      else $error("ack stands too long");
   chk_strobe_pair: assert property (key_strobe_ff && !key_second_ff |-> ##2 (key_strobe_ff && key_second_ff))
      else $error("second key strobe missing");
   chk_flag_has_valid: assert property (search_hit_flag_ff |-> search_hit_valid_ff)
      else $error("hit flag without valid");
   chk_req_pulse: assert property (arr_req_ff |=> !arr_req_ff)
      else $error("array request longer than one cycle");
endmodule // secar_chk
`default_nettype wire

/* File: bench/secar_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// array core stand-in
// ----------------------------------------
module secar_core_model (
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        slow,
   input wire logic        req,
   input wire logic        we,
   input wire logic [14:0] addr,
   input wire logic [67:0] wdata,
   input wire logic [67:0] wmask,
   output logic            rvalid,
   output logic [67:0]     rdata
);
   logic [67:0] mem [0:32767];
   logic [1:0]  cnt_ff;
   logic [14:0] radr_ff;
   initial begin
      for (int i = 0; i < 32768; i++) mem[i] = 68'hA_5A5A_5A5A_0000_0000 ^ {53'h0, i[14:0]};
   end
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 2'h0;
         rvalid <= 1'h0;
         rdata  <= 68'h0;
      end else begin
         rvalid <= (cnt_ff == 2'h1);
         // data toggles whenever not valid
         rdata  <= (cnt_ff == 2'h1) ? mem[radr_ff] : ~rdata;
         if (req && !we) begin
            cnt_ff  <= slow ? 2'h3 : 2'h1;
            radr_ff <= addr;
         end else if (cnt_ff != 2'h0) begin
            cnt_ff <= cnt_ff - 2'h1;
         end
         if (req && we) begin
            mem[addr] <= (mem[addr] & ~wmask) | (wdata & wmask);
         end
      end
   end
endmodule // secar_core_model
`default_nettype wire

/* File: bench/secar_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module secar_top_tb;
   localparam logic [4:0]  own_id = 5'h03;
   localparam logic [67:0] mk = 68'hF_FFFF_0000_FFFF_00FF;
   localparam logic [67:0] va = 68'h1_1111_2222_3333_4444;
   localparam logic [67:0] vb = 68'h8_8888_7777_6666_5555;
   typedef struct {logic [5:0] a; logic [67:0] w; logic [67:0] e;} secar_row_t;
   logic        clk_sys, reset_n, clock_phase_n, cmd_valid, core_hit, core_all_full, slow;
   logic [4:0]  dev_id;
   logic [8:0]  cmd;
   logic [67:0] dq_in, dq_out_ff, key_ff, key_care_ff, arr_wdata_ff, arr_wmask_ff, arr_rdata, care_seen, key_seen;
   logic        dq_oe_n_ff, ack_ff, full_flag_ff, search_hit_flag_ff, search_hit_valid_ff;
   logic        key_strobe_ff, key_second_ff, arr_req_ff, arr_we_ff, arr_rvalid;
   logic [6:0]  local_hit_in, full_chain_in;
   logic [2:0]  block_hit_in, block_hit_out_ff;
   logic [1:0]  local_hit_out_ff, full_chain_out_ff, core_entry_size;
   logic [14:0] core_hit_index, core_next_free, arr_addr_ff;
   logic [5:0]  casc_seen;
   int          failures = 0, checked = 0, hits = 0, h0;
   secar_row_t  rows [5] = '{'{6'h20, mk, mk}, '{6'h21, mk, mk}, '{6'h2A, va, va}, '{6'h2F, vb, vb},
                             '{6'h3D, vb, 68'h0}};
   secar_top i_secar_top (.clk_sys(clk_sys), .reset_n(reset_n), .clock_phase_n(clock_phase_n), .dev_id(dev_id),
      .cmd_valid(cmd_valid), .cmd(cmd), .dq_in(dq_in), .dq_out_ff(dq_out_ff), .dq_oe_n_ff(dq_oe_n_ff),
      .ack_ff(ack_ff), .local_hit_in(local_hit_in), .block_hit_in(block_hit_in), .full_chain_in(full_chain_in),
      .local_hit_out_ff(local_hit_out_ff), .block_hit_out_ff(block_hit_out_ff),
      .full_chain_out_ff(full_chain_out_ff), .full_flag_ff(full_flag_ff), .search_hit_flag_ff(search_hit_flag_ff),
      .search_hit_valid_ff(search_hit_valid_ff), .key_ff(key_ff), .key_care_ff(key_care_ff),
      .key_strobe_ff(key_strobe_ff), .key_second_ff(key_second_ff), .core_hit(core_hit),
      .core_hit_index(core_hit_index), .core_entry_size(core_entry_size), .core_all_full(core_all_full),
      .core_next_free(core_next_free), .arr_req_ff(arr_req_ff), .arr_we_ff(arr_we_ff), .arr_addr_ff(arr_addr_ff),
      .arr_wdata_ff(arr_wdata_ff), .arr_wmask_ff(arr_wmask_ff), .arr_rvalid(arr_rvalid), .arr_rdata(arr_rdata));
   secar_core_model i_secar_core_model (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow), .req(arr_req_ff),
      .we(arr_we_ff), .addr(arr_addr_ff), .wdata(arr_wdata_ff), .wmask(arr_wmask_ff), .rvalid(arr_rvalid),
      .rdata(arr_rdata));
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      clock_phase_n <= ~clock_phase_n;
      if (key_strobe_ff === 1'h1) care_seen <= key_care_ff;
      if (key_strobe_ff === 1'h1) key_seen <= key_ff;
      if (search_hit_flag_ff === 1'h1) hits <= hits + 1;
      if (key_strobe_ff === 1'h1 && key_second_ff === 1'h0) casc_seen <= 6'h00;
      else casc_seen <= casc_seen | {search_hit_valid_ff, block_hit_out_ff, local_hit_out_ff};
   end
   function automatic logic [67:0] ra(input logic [4:0] id, input logic [5:0] a);
      return {39'h0, id, 18'h0, a};
   endfunction
   function automatic logic [67:0] ia(input logic [2:0] s);
      return {39'h0, own_id, s, 2'h3, 19'h0};
   endfunction
   task automatic cmp(input logic [67:0] seen, input logic [67:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic word(input logic [8:0] c, input logic [67:0] d);
      cmd_valid <= 1'h1;
      cmd <= c;
      dq_in <= d;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [67:0] a, input logic [67:0] d);
      word(9'h001, a);
      word(9'h001, d);
      cmd_valid <= 1'h0;
      @(posedge clk_sys);
   endtask
   task automatic rdc(input logic [67:0] a, input logic eo, input logic [67:0] e);
      logic        ok;
      logic [67:0] got;
      ok = 1'h0;
      got = 68'h0;
      word(9'h000, a);
      cmd_valid <= 1'h0;
      for (int i = 0; i < 12 && !ok; i++) begin
         #1;
         if (ack_ff === 1'h1) begin
            ok = 1'h1;
            got = dq_out_ff;
         end else @(posedge clk_sys);
      end
      repeat (3) @(posedge clk_sys);
      cmp(ok, eo);
      if (eo) cmp(got, e);
   endtask
   task automatic srch(input logic [3:0] cp, input logic [2:0] s, input logic [67:0] a, input logic [67:0] b,
                       input logic h, input logic [14:0] ix, input logic [1:0] es, input logic [6:0] lh);
      core_hit <= h;
      core_hit_index <= ix;
      core_entry_size <= es;
      local_hit_in <= lh;
      word({cp, 3'h0, 2'h2}, a);
      word({4'h0, s, 2'h2}, b);
      cmd_valid <= 1'h0;
      repeat (6) @(posedge clk_sys);
      local_hit_in <= 7'h00;
   endtask
   task automatic summarize;
      if (failures == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #500000;
      failures++;
      summarize;
   end
   initial begin
      reset_n = 1'h0; clock_phase_n = 1'h1; cmd_valid = 1'h0; cmd = 9'h000; dq_in = 68'h0; slow = 1'h0;
      core_hit = 1'h0; core_all_full = 1'h0; core_hit_index = 15'h0; core_entry_size = 2'h2;
      core_next_free = 15'h0; dev_id = own_id; local_hit_in = 7'h00; block_hit_in = 3'h0;
      full_chain_in = 7'h7F;
      repeat (8) @(posedge clk_sys);
      cmp(dq_oe_n_ff, 1'h1);
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'h1;
      repeat (6) @(posedge clk_sys);
      rdc(ra(own_id, 6'h38), 1'h0, 68'h0);
      wr(ra(own_id, 6'h38), 68'h82);
      rdc(ra(own_id, 6'h38), 1'h1, 68'h82);
      foreach (rows[i]) begin
         wr(ra(own_id, rows[i].a), rows[i].w);
         rdc(ra(own_id, rows[i].a), 1'h1, rows[i].e);
      end
      h0 = hits;
      srch(4'h3, 3'h2, va, vb, 1'h1, 15'h1235, 2'h2, 7'h00);
      cmp(care_seen, mk);
      cmp(key_seen, vb);
      cmp(casc_seen, 6'h3F);
      cmp(hits != h0, 1'h1);
      rdc(ra(own_id, 6'h06), 1'h1, va);
      rdc(ra(own_id, 6'h07), 1'h1, vb);
      rdc(ra(own_id, 6'h32), 1'h1, {36'h0, 1'h1, 16'h0, 15'h1234});
      h0 = hits;
      srch(4'h4, 3'h5, va, vb, 1'h1, 15'h2227, 2'h3, 7'h01);
      cmp(hits == h0, 1'h1);
      cmp(casc_seen, 6'h1F);
      rdc(ra(own_id, 6'h35), 1'h1, {53'h0, 15'h2224});
      srch(4'h3, 3'h2, vb, va, 1'h0, 15'h0777, 2'h2, 7'h00);
      cmp(casc_seen, 6'h20);
      rdc(ra(own_id, 6'h32), 1'h1, {36'h0, 1'h1, 16'h0, 15'h1234});
      wr(ra(own_id, 6'h06), 68'h0);
      rdc(ra(own_id, 6'h06), 1'h1, vb);
      rdc(ia(3'h5), 1'h0, 68'h0);
      for (int k = 0; k < 2; k++) begin
         slow <= k[0];
         rdc(ia(3'h2), 1'h1, 68'hA_5A5A_5A5A_0000_0000 ^ {53'h0, 15'h1234});
      end
      wr(ia(3'h2), vb);
      rdc(ia(3'h2), 1'h1, (68'hA_5A5A_5A5A_0000_1234 & ~mk) | (vb & mk));
      rdc(ra(5'h04, 6'h38), 1'h0, 68'h0);
      rdc(ra(5'h1F, 6'h38), 1'h1, 68'h82);
      wr(ra(5'h1F, 6'h38), 68'h02);
      rdc(ra(5'h1F, 6'h38), 1'h0, 68'h0);
      rdc(ra(own_id, 6'h38), 1'h1, 68'h02);
      core_all_full <= 1'h1;
      repeat (3) @(posedge clk_sys);
      #1;
      cmp(full_flag_ff, 1'h1);
      cmp(full_chain_out_ff, 2'h3);
      @(posedge clk_sys);
      full_chain_in <= 7'h7E;
      repeat (3) @(posedge clk_sys);
      #1;
      cmp(full_flag_ff, 1'h0);
      summarize;
   end
endmodule // secar_top_tb
bind secar_top secar_chk i_secar_chk (.clk_sys(clk_sys), .reset_n(reset_n), .core_all_full(core_all_full),
   .full_chain_in(full_chain_in), .local_hit_out_ff(local_hit_out_ff), .block_hit_out_ff(block_hit_out_ff),
   .full_chain_out_ff(full_chain_out_ff), .full_flag_ff(full_flag_ff), .ack_ff(ack_ff), .dq_oe_n_ff(dq_oe_n_ff),
   .key_strobe_ff(key_strobe_ff), .key_second_ff(key_second_ff), .search_hit_flag_ff(search_hit_flag_ff),
   .search_hit_valid_ff(search_hit_valid_ff), .arr_req_ff(arr_req_ff));
`default_nettype wire
